// ==== verilog/router_pkg.sv ====
// constants shared by the serial command router and its fifo
package router_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned ROUTE_BAUD    = 9600;
    localparam int unsigned PROG_BAUD     = 19200;
    localparam int unsigned ROUTE_DIV     = CLK_HZ / ROUTE_BAUD;
    localparam int unsigned PROG_DIV      = CLK_HZ / PROG_BAUD;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned NUM_PORTS     = 4;
    localparam int unsigned LAMP_MS       = 50;
    localparam int unsigned LAMP_CYCLES   = CLK_HZ / 1000 * LAMP_MS;
    localparam logic [7:0]  CHAR_CR       = 8'h0d;
    localparam logic [7:0]  CHAR_PORT1    = 8'h31;
    localparam logic [7:0]  CHAR_PORT4    = 8'h34;
    localparam int unsigned LINE_MAX      = 32;
    localparam int unsigned FIFO_DEPTH    = 8;
    typedef enum logic { MODE_ROUTER, MODE_PROGRAM } run_mode_t;
endpackage

// ==== verilog/word_fifo.sv ====
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo import router_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // honest flags straight from the count
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];

    // pointer and count update
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                mem_reg[wr_reg] <= in_data;
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop)
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== verilog/serial_command_router.sv ====
// four-port serial command router with host and drive uarts
//
// What this block does
// - 9600 baud, 8 data, 1 stop, no parity
// - no flow-control lines on any link
// - forward host commands to four drives, relay replies
// - leading port digit sends line to that drive
// - no address digit means broadcast to all
// - reply is prefixed with replying port digit
// - traffic lamp pulses once per host command
// - power lamp lit while drive one powered
// - routing runs only in router-only power-up mode
// - program mode runs without host attached
// - host port runs 19200 in program mode
// - input reads on only while current flows
// - four independently controlled switching outputs
// - operator terminal shares the host port
`timescale 1ns/1ps
module serial_command_router import router_pkg::*; #(
    parameter int LAMP_TICKS  = LAMP_CYCLES,
    parameter int ROUTE_TICKS = ROUTE_DIV,
    parameter int PROG_TICKS  = PROG_DIV
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    // host or operator terminal serial port
    input  wire logic                 host_rx,
    output logic                      host_tx,
    // drive serial ports
    input  wire logic [NUM_PORTS-1:0] drive_rx,
    output logic      [NUM_PORTS-1:0] drive_tx,
    // mode and drive one supply sense
    input  wire logic                 router_only_mode,
    input  wire logic                 drive1_power,
    // isolated inputs and outputs
    input  wire logic [3:0]           opto_current,
    output logic      [3:0]           opto_in_state,
    input  wire logic [3:0]           prog_out_set,
    output logic      [3:0]           switch_out,
    // program engine host port in program mode
    output logic                      prog_rx_valid,
    output logic      [7:0]           prog_rx_data,
    // lamps
    output logic                      host_traffic_lamp,
    output logic                      power_lamp
);
    localparam int NR = NUM_PORTS + 1;  // receivers: drives then host
    localparam int LW = $clog2(LINE_MAX);

    // two-flop synchronisers for every pin input
    logic [NR-1:0] rx_s1_reg, rx_s2_reg;
    logic [3:0]    io_s1_reg, io_s2_reg;
    logic [1:0]    mode_s1_reg, mode_s2_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_s1_reg   <= '1;
            rx_s2_reg   <= '1;
            io_s1_reg   <= '0;
            io_s2_reg   <= '0;
            mode_s1_reg <= '0;
            mode_s2_reg <= '0;
        end else begin
            rx_s1_reg   <= {host_rx, drive_rx};
            rx_s2_reg   <= rx_s1_reg;
            io_s1_reg   <= opto_current;
            io_s2_reg   <= io_s1_reg;
            mode_s1_reg <= {drive1_power, router_only_mode};
            mode_s2_reg <= mode_s1_reg;
        end
    end

    // power-up mode captured after reset, held until next reset
    // mode latched once
    run_mode_t mode_reg;
    logic      mode_taken_reg;
    logic [1:0] mode_wait_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_reg       <= MODE_ROUTER;
            mode_taken_reg <= 1'b0;
            mode_wait_reg  <= '0;
        end else if (!mode_taken_reg) begin
            mode_wait_reg <= mode_wait_reg + 2'd1;
            if (mode_wait_reg == 2'd3) begin
                mode_taken_reg <= 1'b1;
                mode_reg <= mode_s2_reg[0] ? MODE_ROUTER : MODE_PROGRAM;
            end
        end
    end
    wire routing = mode_taken_reg && (mode_reg == MODE_ROUTER);

    wire [15:0] host_div = (mode_reg == MODE_PROGRAM) ?
                           16'(PROG_TICKS) : 16'(ROUTE_TICKS);

    logic [NR-1:0]      rx_valid;
    logic [7:0]         rx_byte [NR];
    logic [NR-1:0]      rxb_reg;
    logic [15:0]        rxc_reg [NR];
    logic [3:0]         rxn_reg [NR];
    logic [7:0]         rxsh_reg [NR];
    logic [NR-1:0]      rxv_reg;
    for (genvar g = 0; g < NR; g++) begin : g_rx
        wire [15:0] div  = (g == NUM_PORTS) ? host_div : 16'(ROUTE_TICKS);
        wire        line = rx_s2_reg[g];
        assign rx_valid[g] = rxv_reg[g];
        assign rx_byte[g]  = rxsh_reg[g];
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                rxb_reg[g]  <= 1'b0;
                rxc_reg[g]  <= '0;
                rxn_reg[g]  <= '0;
                rxsh_reg[g] <= '0;
                rxv_reg[g]  <= 1'b0;
            end else begin
                rxv_reg[g] <= 1'b0;
                if (!rxb_reg[g]) begin
                    if (!line) begin  // start edge, sample mid-bit
                        rxb_reg[g] <= 1'b1;
                        rxc_reg[g] <= div >> 1;
                        rxn_reg[g] <= '0;
                    end
                end else if (rxc_reg[g] != '0) begin
                    rxc_reg[g] <= rxc_reg[g] - 16'd1;
                end else begin
                    rxc_reg[g] <= div - 16'd1;
                    rxn_reg[g] <= rxn_reg[g] + 4'd1;
                    if (rxn_reg[g] == 4'd0 && line)
                        rxb_reg[g] <= 1'b0;  // false start
                    else if (rxn_reg[g] inside {[4'd1:4'd8]})
                        rxsh_reg[g] <= {line, rxsh_reg[g][7:1]};
                    else if (rxn_reg[g] == 4'd9) begin
                        rxb_reg[g] <= 1'b0;
                        rxv_reg[g] <= line;  // bad stop bit drops byte
                    end
                end
            end
        end
    end

    // transmitter shared shape, one per port
    logic [NR-1:0]  tx_go;
    logic [7:0]     tx_byte [NR];
    logic [NR-1:0]  tx_busy_reg;
    logic [15:0]    txc_reg [NR];
    logic [3:0]     txn_reg [NR];
    logic [9:0]     txsh_reg [NR];
    for (genvar g = 0; g < NR; g++) begin : g_tx
        wire [15:0] div = (g == NUM_PORTS) ? host_div : 16'(ROUTE_TICKS);
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                tx_busy_reg[g] <= 1'b0;
                txc_reg[g]     <= '0;
                txn_reg[g]     <= '0;
                txsh_reg[g]    <= '1;
            end else if (!tx_busy_reg[g]) begin
                if (tx_go[g]) begin
                    tx_busy_reg[g] <= 1'b1;
                    txsh_reg[g]    <= {1'b1, tx_byte[g], 1'b0};
                    txc_reg[g]     <= div - 16'd1;
                    txn_reg[g]     <= '0;
                end
            end else if (txc_reg[g] != '0) begin
                txc_reg[g] <= txc_reg[g] - 16'd1;
            end else begin
                txc_reg[g]  <= div - 16'd1;
                txsh_reg[g] <= {1'b1, txsh_reg[g][9:1]};
                txn_reg[g]  <= txn_reg[g] + 4'd1;
                if (txn_reg[g] == 4'd9)
                    tx_busy_reg[g] <= 1'b0;
            end
        end
    end
    assign drive_tx = {txsh_reg[3][0], txsh_reg[2][0],
                       txsh_reg[1][0], txsh_reg[0][0]};
    assign host_tx  = txsh_reg[NUM_PORTS][0];

    // host byte fifo; backs up if line assembly stalls
    logic       hf_valid, hf_ready;
    logic [7:0] hf_data;
    word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) word_fifo_inst (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (rx_valid[NUM_PORTS] && routing),
        .in_ready  (),
        .in_data   (rx_byte[NUM_PORTS]),
        .out_valid (hf_valid),
        .out_ready (hf_ready),
        .out_data  (hf_data)
    );

    // program mode hands host bytes to program engine
    assign prog_rx_valid = rx_valid[NUM_PORTS] &&
                           (mode_reg == MODE_PROGRAM);
    assign prog_rx_data  = rx_byte[NUM_PORTS];

    // line buffer and forward state machine
    typedef enum logic [1:0] { L_COLLECT, L_SEND, L_DONE } line_st_t;
    line_st_t        lst_reg;
    logic [7:0]      line_reg [LINE_MAX];
    logic [LW-1:0]   len_reg, idx_reg;
    logic [3:0]      dest_reg;

    // address decode of a character
    function automatic logic is_addr(input logic [7:0] c);
        return (c >= CHAR_PORT1) && (c <= CHAR_PORT4);
    endfunction

    wire       head_addr = is_addr(line_reg[0]);
    wire [1:0] head_port = 2'(line_reg[0] - CHAR_PORT1);
    // busy rises the edge after a strobe, so no loop through tx_go
    wire       drv_idle  = ~|tx_busy_reg[NUM_PORTS-1:0];
    wire       send_byte = (lst_reg == L_SEND) && drv_idle;
    assign hf_ready = (lst_reg == L_COLLECT);

    // collect until carriage return, then decode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lst_reg  <= L_COLLECT;
            len_reg  <= '0;
            idx_reg  <= '0;
            dest_reg <= '0;
        end else begin
            unique case (lst_reg)
                L_COLLECT: if (hf_valid) begin
                    line_reg[len_reg] <= hf_data;
                    if (len_reg != LW'(LINE_MAX-1))
                        len_reg <= len_reg + 1'b1;  // overflow rewrites last slot
                    if (hf_data == CHAR_CR)
                        lst_reg <= L_DONE;
                end
                L_DONE: begin
                    if (head_addr) begin
                        dest_reg <= 4'b0001 << head_port;
                        idx_reg  <= LW'(1);
                    end else begin
                        dest_reg <= '1;
                        idx_reg  <= '0;
                    end
                    lst_reg <= L_SEND;
                end
                L_SEND: if (send_byte) begin
                    idx_reg <= idx_reg + 1'b1;
                    if (idx_reg == len_reg - 1'b1) begin
                        lst_reg <= L_COLLECT;
                        len_reg <= '0;
                    end
                end
                default: lst_reg <= L_COLLECT;
            endcase
        end
    end

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_dgo
        assign tx_go[g]   = send_byte && dest_reg[g];
        assign tx_byte[g] = line_reg[idx_reg];
    end

    // reply relay: one drive owns host tx for a whole reply line
    logic                 rep_act_reg, rep_pfx_reg;
    logic [1:0]           rep_port_reg;
    logic [7:0]           rep_hold [NUM_PORTS];
    logic [NUM_PORTS-1:0] rep_has;
    logic [NUM_PORTS-1:0] rep_pop;
    wire                  host_free = !tx_busy_reg[NUM_PORTS];
    logic [1:0]           pick;
    logic                 any_wait;

    // a byte fifo per drive; the prefix costs a byte time per
    // line, so a single holding slot would lose every reply tail
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_rep
        assign rep_pop[g] = tx_go[NUM_PORTS] && !rep_pfx_reg &&
                            (rep_port_reg == 2'(g));
        word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) word_fifo_inst (
            .ref_clk   (ref_clk),
            .srst      (srst),
            .in_valid  (rx_valid[g] && routing),
            .in_ready  (),
            .in_data   (rx_byte[g]),
            .out_valid (rep_has[g]),
            .out_ready (rep_pop[g]),
            .out_data  (rep_hold[g])
        );
    end

    // lowest numbered waiting drive wins the host line
    always_comb begin
        pick = '0;
        any_wait = |rep_has;
        for (int i = NUM_PORTS - 1; i >= 0; i--)
            if (rep_has[i]) pick = 2'(i);
    end
    wire [7:0] cur_byte = rep_hold[rep_port_reg];
    assign tx_go[NUM_PORTS] = host_free && rep_act_reg &&
                              (rep_pfx_reg || rep_has[rep_port_reg]);
    assign tx_byte[NUM_PORTS] = rep_pfx_reg ?
                                CHAR_PORT1 + 8'(rep_port_reg) : cur_byte;

    // reply ownership; released once the carriage return goes out
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rep_act_reg  <= 1'b0;
            rep_pfx_reg  <= 1'b0;
            rep_port_reg <= '0;
        end else if (!rep_act_reg && any_wait) begin
            rep_act_reg  <= 1'b1;
            rep_pfx_reg  <= 1'b1;
            rep_port_reg <= pick;
        end else if (tx_go[NUM_PORTS]) begin
            rep_pfx_reg <= 1'b0;
            if (!rep_pfx_reg && cur_byte == CHAR_CR)
                rep_act_reg <= 1'b0;
        end
    end

    logic [31:0] lamp_cnt_reg;
    always_ff @(posedge ref_clk) begin
        if (srst)
            lamp_cnt_reg <= '0;
        else if (lst_reg == L_DONE)
            lamp_cnt_reg <= 32'(LAMP_TICKS);
        else if (lamp_cnt_reg != '0)
            lamp_cnt_reg <= lamp_cnt_reg - 32'd1;
    end

    // registered lamp and io outputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            host_traffic_lamp <= 1'b0;
            power_lamp        <= 1'b0;
            opto_in_state     <= '0;
            switch_out        <= '0;
        end else begin
            host_traffic_lamp <= (lamp_cnt_reg != '0);
            power_lamp        <= mode_s2_reg[1];
            opto_in_state     <= io_s2_reg;
            switch_out        <= prog_out_set;
        end
    end
endmodule

// ==== testbench/router_properties.sv ====
// port-level assertions for the serial command router
`timescale 1ns/1ps
module router_properties import router_pkg::*; #(
    parameter int LAMP_TICKS  = LAMP_CYCLES,
    parameter int ROUTE_TICKS = ROUTE_DIV
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       srst,
    // serial lines
    input wire logic       host_rx,
    input wire logic       host_tx,
    input wire logic [3:0] drive_rx,
    input wire logic [3:0] drive_tx,
    // mode and sense
    input wire logic       router_only_mode,
    input wire logic       drive1_power,
    input wire logic [3:0] opto_current,
    input wire logic [3:0] opto_in_state,
    input wire logic [3:0] prog_out_set,
    input wire logic [3:0] switch_out,
    // program port and lamps
    input wire logic       prog_rx_valid,
    input wire logic [7:0] prog_rx_data,
    input wire logic       host_traffic_lamp,
    input wire logic       power_lamp
);
    int unsigned lamp_run_reg;
    int unsigned host_low_reg;
    int unsigned drv_low_reg;
    // run lengths; a bit cell off by one shows as a remainder
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lamp_run_reg <= 0;
            host_low_reg <= 0;
            drv_low_reg  <= 0;
        end else begin
            lamp_run_reg <= host_traffic_lamp ? lamp_run_reg + 1 : 0;
            host_low_reg <= host_tx ? 0 : host_low_reg + 1;
            drv_low_reg  <= drive_tx[0] ? 0 : drv_low_reg + 1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // inputs must hold four samples before the output may be judged
    sequence opto_settled; $stable(opto_current)[*4]; endsequence
    sequence power_settled; $stable(drive1_power)[*4]; endsequence
    chk_reset_idle_lines: assert property ($fell(srst) |-> host_tx
        && drive_tx == 4'hf && !host_traffic_lamp && switch_out == 4'h0)
        else $error("lines not idle after reset");
    chk_opto_sense: assert property (
        opto_settled |-> opto_in_state == opto_current)
        else $error("input state does not follow current");
    chk_power_lamp: assert property (
        power_settled |-> power_lamp == drive1_power)
        else $error("power lamp does not follow drive one");
    chk_switch_drive: assert property (
        !srst |=> switch_out == $past(prog_out_set))
        else $error("switch output not one cycle behind request");
    chk_lamp_width: assert property (
        $fell(host_traffic_lamp) |-> lamp_run_reg == LAMP_TICKS)
        else $error("traffic lamp pulse has wrong width");
    chk_host_bit_len: assert property (
        $rose(host_tx) |-> host_low_reg % ROUTE_TICKS == 0)
        else $error("host bit cell length wrong");
    chk_drive_bit_len: assert property (
        $rose(drive_tx[0]) |-> drv_low_reg % ROUTE_TICKS == 0)
        else $error("drive bit cell length wrong");
    chk_prog_pulse: assert property (
        prog_rx_valid |=> !prog_rx_valid)
        else $error("program byte strobe longer than one cycle");
    chk_prog_quiet: assert property (
        router_only_mode |-> !prog_rx_valid)
        else $error("program byte strobe in router mode");
    chk_drive_hold: assert property (
        !router_only_mode |-> drive_tx == 4'hf)
        else $error("drive line active in program mode");
endmodule

bind serial_command_router router_properties #(.LAMP_TICKS(LAMP_TICKS),
    .ROUTE_TICKS(ROUTE_TICKS))
    router_properties_inst (.ref_clk(ref_clk), .srst(srst),
    .host_rx(host_rx), .host_tx(host_tx), .drive_rx(drive_rx),
    .drive_tx(drive_tx), .router_only_mode(router_only_mode),
    .drive1_power(drive1_power), .opto_current(opto_current),
    .opto_in_state(opto_in_state), .prog_out_set(prog_out_set),
    .switch_out(switch_out), .prog_rx_valid(prog_rx_valid),
    .prog_rx_data(prog_rx_data), .host_traffic_lamp(host_traffic_lamp),
    .power_lamp(power_lamp));

// ==== testbench/serial_end_model.sv ====
// far end of one serial link: byte sender and mid-bit receiver
`timescale 1ns/1ps
module serial_end_model import router_pkg::*; #(
    parameter int BIT_TICKS = ROUTE_DIV
) (
    // clock
    input  wire logic       clk,
    // serial lines
    input  wire logic       line_in,
    output logic            line_out,
    // received bytes
    output logic            rx_valid,
    output logic      [7:0] rx_data
);
    // bit cell, switched to the faster rate by the bench
    int div = BIT_TICKS;
    // idle mark; no handshake paces the sender
    initial line_out = 1'b1;
    // start, eight bits lsb first, one stop, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            line_out = f[i];
            repeat (div - 1) @(negedge clk);
        end
    endtask
    // sample mid-cell; a bad stop bit drops the byte
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        forever begin
            @(negedge line_in);
            repeat (div / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge clk);
                rx_data[i] = line_in;
            end
            repeat (div) @(posedge clk);
            rx_valid <= line_in;
            @(posedge clk);
            rx_valid <= 1'b0;
        end
    end
endmodule

// ==== testbench/tb_serial_command_router.sv ====
// self-checking bench for the serial command router
`timescale 1ns/1ps
module tb_serial_command_router import router_pkg::*;;
    localparam int LAMP_SIM = 10;
    // scaled bit cells keep the run short; ratio of the rates is kept
    localparam int DIV_SIM  = 16;
    localparam int PROG_SIM = 8;
    localparam int LIMIT    = 40_000;
    logic       ref_clk, srst, host_rx, host_tx;
    logic [3:0] drive_rx, drive_tx, opto_current, opto_in_state;
    logic [3:0] prog_out_set, switch_out;
    logic       router_only_mode, drive1_power, prog_rx_valid;
    logic       host_traffic_lamp, power_lamp;
    logic [7:0] prog_rx_data, b;
    logic [5:0] got_v;
    logic [7:0] got_d [6];
    logic [7:0] exp_q [6][$];
    int         num_errors, n_compared, lamp_pulses, cycles;

    serial_command_router #(.LAMP_TICKS(LAMP_SIM), .ROUTE_TICKS(DIV_SIM),
        .PROG_TICKS(PROG_SIM)) serial_command_router_inst (
        .ref_clk(ref_clk), .srst(srst), .host_rx(host_rx), .host_tx(host_tx),
        .drive_rx(drive_rx), .drive_tx(drive_tx),
        .router_only_mode(router_only_mode), .drive1_power(drive1_power),
        .opto_current(opto_current), .opto_in_state(opto_in_state),
        .prog_out_set(prog_out_set), .switch_out(switch_out),
        .prog_rx_valid(prog_rx_valid), .prog_rx_data(prog_rx_data),
        .host_traffic_lamp(host_traffic_lamp), .power_lamp(power_lamp));
    serial_end_model #(.BIT_TICKS(DIV_SIM)) host_m (.clk(ref_clk),
        .line_in(host_tx), .line_out(host_rx), .rx_valid(got_v[4]),
        .rx_data(got_d[4]));
    for (genvar i = 0; i < 4; i++) begin : drv_g
        serial_end_model #(.BIT_TICKS(DIV_SIM)) m (.clk(ref_clk),
            .line_in(drive_tx[i]), .line_out(drive_rx[i]),
            .rx_valid(got_v[i]), .rx_data(got_d[i]));
    end
    // program port results join the same watcher as channel five
    assign got_v[5] = prog_rx_valid;
    assign got_d[5] = prog_rx_data;

    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask

    // an unexpected byte meets an unknown and so always mismatches
    task automatic check_byte(input int c, input logic [7:0] got);
        check_val(got, exp_q[c].size() ? exp_q[c].pop_front() : 8'hxx);
    endtask

    task automatic expect_str(input int c, input string s);
        for (int i = 0; i < s.len(); i++) exp_q[c].push_back(s[i]);
    endtask

    task automatic send(input int c, input string s);
        for (int i = 0; i < s.len(); i++)
            case (c)
                0: drv_g[0].m.send_byte(s[i]);
                1: drv_g[1].m.send_byte(s[i]);
                2: drv_g[2].m.send_byte(s[i]);
                3: drv_g[3].m.send_byte(s[i]);
                default: host_m.send_byte(s[i]);
            endcase
    endtask

    function automatic int pending();
        int t;
        t = 0;
        for (int c = 0; c < 6; c++) t += exp_q[c].size();
        return t;
    endfunction

    // the watchdog bounds this wait; the tail lets stray bytes show
    task automatic drain(input string name);
        while (pending() != 0) @(negedge ref_clk);
        repeat (20 * DIV_SIM) @(negedge ref_clk);
        check_val(8'(pending()), 8'h00);
        $display("test %s done", name);
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (8) @(negedge ref_clk);
        srst = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask

    // result watcher, timeout and lamp pulse count
    always @(posedge ref_clk) begin
        for (int c = 0; c < 6; c++)
            if (got_v[c] === 1'b1) check_byte(c, got_d[c]);
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            give_verdict();
        end
    end
    always @(posedge host_traffic_lamp) lamp_pulses++;

    initial begin
        srst = 1'b1;
        router_only_mode = 1'b1;
        drive1_power = 1'b0;
        opto_current = 4'h0;
        prog_out_set = 4'h0;
        void'($urandom(32'hcf82));
        do_reset();
        check_val({7'h0, host_tx}, 8'h01);
        check_val({4'h0, drive_tx}, 8'h0f);
        check_val({6'h0, host_traffic_lamp, power_lamp}, 8'h00);
        // first pass drives no opto current, then random levels
        for (int i = 0; i < 8; i++) begin
            opto_current = (i == 0) ? 4'h0 : 4'($urandom);
            prog_out_set = 4'($urandom);
            drive1_power = i[0];
            // five cycles so the settled-input assertions also fire
            repeat (5) @(negedge ref_clk);
            check_val({4'h0, opto_in_state}, {4'h0, opto_current});
            check_val({4'h0, switch_out}, {4'h0, prog_out_set});
            check_val({7'h0, power_lamp}, {7'h0, drive1_power});
        end
        $display("test isolated io done");
        drive1_power = 1'b1;
        expect_str(0, "a\015");
        expect_str(1, "b\015");
        expect_str(2, "c\015");
        expect_str(3, "d\015");
        send(4, "1a\0152b\0153c\0154d\015");
        drain("addressed");
        // digit five is no address, so the whole line goes to all
        for (int p = 0; p < 4; p++) expect_str(p, "5\015");
        send(4, "5\015");
        drain("broadcast");
        check_val(8'(lamp_pulses), 8'h05);
        expect_str(4, "3R\015");
        send(2, "R\015");
        drain("reply port three");
        expect_str(4, "1M\015");
        send(0, "M\015");
        drain("reply port one");
        router_only_mode = 1'b0;
        do_reset();
        host_m.div = PROG_SIM;
        b = 8'($urandom);
        exp_q[5].push_back(b);
        host_m.send_byte(b);
        drain("program mode");
        give_verdict();
    end
endmodule
